// ---- rtl/frame_rx_pkg.sv ----
// How it works
// R1 - Serial bytes outside a frame, before a valid header, are ignored.
// R2 - Frame is header, byte count, command packets, then checksum.
// R3 - One frame may carry one or several commands, handled together.
// R4 - Commands run only after the count and checksum are both validated.
// R5 - First byte of each packet is the command; it sets the length.
// R6 - Parser holds the packet length of every supported command.
// R7 - Pointer-set packet is three bytes; two address bytes load the pointer.
// R8 - Link is point-to-point; host talks to one device at a time.
// R9 - Auto-transmit input sends a fixed data frame without host requests.
// R10 - Checksum is the sum of all preceding frame bytes modulo 256.
// R11 - Checksum failure runs no command and replies with the fail code.
// R12 - Data frames use acknowledge as header and the same checksum.
// R13 - Link runs at 4.8 kbps, start, eight data bits, stop.
// R14 - Bad header or count that disagrees with packets drops the frame.
// R15 - Partial frame is dropped after an inter-byte timeout.
package frame_rx_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int BAUD_BPS = 4800;
	localparam int BIT_CYCLES = CLK_HZ / BAUD_BPS;
	localparam int TIMEOUT_US = 10_000;
	localparam int TIMEOUT_CYCLES = TIMEOUT_US * (CLK_HZ / 1_000_000);
	localparam int AUTO_PERIOD_MS = 100;
	localparam int AUTO_CYCLES = AUTO_PERIOD_MS * (CLK_HZ / 1000);
	localparam logic [3:0] STOP_BIT_IDX = 4'h9;
	localparam logic [7:0] FRAME_HEADER = 8'ha5;
	localparam logic [7:0] ACK_BYTE = 8'h06;
	localparam logic [7:0] CHECKSUM_FAIL_REPLY = 8'h51;
	localparam logic [7:0] MIN_FRAME_LEN = 8'h04;
	localparam logic [7:0] FIRST_CMD_IDX = 8'h02;
	localparam logic [7:0] AUTO_FRAME_LEN = 8'h07;
	localparam int AUTO_DATA_BYTES = 4;
	localparam logic [7:0] CMD_READ16 = 8'h52;
	localparam logic [7:0] CMD_READ32 = 8'h44;
	localparam logic [7:0] CMD_WRITE16 = 8'h57;
	localparam logic [7:0] CMD_WRITE32 = 8'h45;
	localparam logic [7:0] CMD_READN = 8'h4e;
	localparam logic [7:0] CMD_WRITEN = 8'h4d;
	localparam logic [7:0] CMD_SELECT = 8'h4c;
	localparam logic [7:0] CMD_DESELECT = 8'h4b;
	localparam logic [7:0] CMD_SET_PTR = 8'h41;
	localparam logic [7:0] CMD_SAVE = 8'h53;
	localparam logic [7:0] CMD_PAGE_READ = 8'h42;
	localparam logic [7:0] CMD_PAGE_WRITE = 8'h50;
	localparam logic [7:0] CMD_ERASE = 8'h4f;
	localparam logic [7:0] CMD_CAL_GAIN = 8'h5a;
	localparam logic [7:0] CMD_CAL_REACT = 8'h7a;
	localparam logic [7:0] CMD_CAL_FREQ = 8'h76;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RECV = 5'h02,
		ST_CHECK = 5'h04,
		ST_DISPATCH = 5'h08,
		ST_REPLY = 5'h10
	} rx_state_e;
endpackage

// ---- rtl/host_frame_command_receiver.sv ----
module host_frame_command_receiver #(
	parameter int BIT_CYC = frame_rx_pkg::BIT_CYCLES,
	parameter int TIMEOUT_CYC = frame_rx_pkg::TIMEOUT_CYCLES,
	parameter int AUTO_CYC = frame_rx_pkg::AUTO_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic uart_rx,
	output logic uart_tx,
	input wire logic auto_tx_en,
	input wire logic [31:0] auto_data,
	output logic cmd_valid,
	output logic [7:0] cmd_code,
	output logic [15:0] cmd_arg,
	output logic [15:0] addr_ptr
);
	import frame_rx_pkg::*;

	serial_if lnk ();
	rx_state_e state_r;
	logic [7:0] frame_mem [0:255];
	logic [7:0] reply_r [0:6];
	logic [7:0] idx_r, count_r, sum_r, pkt_r, reply_len_r, tx_idx_r;
	logic [23:0] tmo_r, auto_r;
	logic cmd_valid_r, tx_go_r;
	logic [7:0] cmd_code_r, tx_byte_r;
	logic [15:0] cmd_arg_r, addr_ptr_r;
	logic [8:0] pkt_next;
	logic [7:0] cur_len, last_idx, auto_sum;
	logic rx_last, auto_fire, reply_done;

	serial_port #(.BIT_CYC(BIT_CYC)) u_port ( // R8
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.rx_pin(uart_rx),
		.lnk(lnk.port)
	);

	assign uart_tx = lnk.tx_line;
	assign cmd_valid = cmd_valid_r;
	assign cmd_code = cmd_code_r;
	assign cmd_arg = cmd_arg_r;
	assign addr_ptr = addr_ptr_r;
	assign lnk.tx_go = tx_go_r;
	assign lnk.tx_byte = tx_byte_r;

	// Zero marks an unknown command, which rejects the whole frame
	function automatic logic [7:0] packet_len(input logic [7:0] code,
			input logic [7:0] nbytes);
		unique case (code) // R5 R6
			CMD_READ16, CMD_READ32: packet_len = 8'h01;
			CMD_WRITE16: packet_len = 8'h03;
			CMD_WRITE32: packet_len = 8'h05;
			CMD_SET_PTR: packet_len = 8'h03; // R7
			CMD_PAGE_WRITE: packet_len = 8'h12;
			CMD_WRITEN: packet_len = nbytes + 8'h02;
			CMD_READN, CMD_SELECT, CMD_DESELECT, CMD_SAVE, CMD_PAGE_READ,
			CMD_ERASE, CMD_CAL_GAIN, CMD_CAL_REACT,
			CMD_CAL_FREQ: packet_len = 8'h02;
			default: packet_len = 8'h00;
		endcase
	endfunction

	always_comb begin
		cur_len = packet_len(frame_mem[pkt_r], frame_mem[pkt_r + 8'h01]);
		pkt_next = {1'b0, pkt_r} + {1'b0, cur_len};
		last_idx = count_r - 8'h01;
		rx_last = (idx_r != 8'h01) && (idx_r == last_idx);
		auto_fire = auto_tx_en && auto_r == 24'(AUTO_CYC - 1);
		auto_sum = ACK_BYTE + AUTO_FRAME_LEN + auto_data[31:24]
			+ auto_data[23:16] + auto_data[15:8] + auto_data[7:0]; // R10 R12
		reply_done = !lnk.tx_busy && !tx_go_r && tx_idx_r == reply_len_r;
	end

	// Frame buffer: every byte after the header is held until the frame validates
	always_ff @(posedge clk_sys) begin
		if (lnk.rx_valid && state_r == ST_RECV) begin
			frame_mem[idx_r] <= lnk.rx_byte;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state_r <= ST_IDLE;
			idx_r <= 8'h00;
			count_r <= 8'h00;
			sum_r <= 8'h00;
			pkt_r <= 8'h00;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (lnk.rx_valid && lnk.rx_byte == FRAME_HEADER) begin
						state_r <= ST_RECV; // R1 R2 R14
						idx_r <= 8'h01;
						sum_r <= lnk.rx_byte;
					end else if (auto_fire) begin
						state_r <= ST_REPLY; // R9
					end
				end
				ST_RECV: begin
					if (tmo_r == 24'(TIMEOUT_CYC - 1)) begin
						state_r <= ST_IDLE; // R15
					end else if (lnk.rx_valid) begin
						idx_r <= idx_r + 8'h01;
						sum_r <= sum_r + lnk.rx_byte; // R10
						if (idx_r == 8'h01) begin
							count_r <= lnk.rx_byte;
							if (lnk.rx_byte < MIN_FRAME_LEN) begin
								state_r <= ST_IDLE; // R14
							end
						end else if (rx_last) begin
							pkt_r <= FIRST_CMD_IDX;
							state_r <= (sum_r == lnk.rx_byte) ? ST_CHECK
								: ST_REPLY; // R4 R11
						end
					end
				end
				ST_CHECK: begin
					// Dry walk proves packets end exactly at the checksum
					if (cur_len == 8'h00 || pkt_next > {1'b0, last_idx}) begin
						state_r <= ST_IDLE; // R14
					end else if (pkt_next == {1'b0, last_idx}) begin
						pkt_r <= FIRST_CMD_IDX;
						state_r <= ST_DISPATCH; // R4
					end else begin
						pkt_r <= pkt_next[7:0];
					end
				end
				ST_DISPATCH: begin
					pkt_r <= pkt_next[7:0]; // R3
					if (pkt_next == {1'b0, last_idx}) begin
						state_r <= ST_REPLY;
					end
				end
				ST_REPLY: begin
					if (reply_done) begin
						state_r <= ST_IDLE;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b || state_r != ST_RECV || lnk.rx_valid) begin
			tmo_r <= 24'h000000;
		end else begin
			tmo_r <= tmo_r + 24'h000001;
		end
	end

	// Period restarts while disabled or while host traffic is in progress
	always_ff @(posedge clk_sys) begin
		if (!rst_b || !auto_tx_en || state_r != ST_IDLE || auto_fire) begin
			auto_r <= 24'h000000;
		end else begin
			auto_r <= auto_r + 24'h000001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			cmd_valid_r <= 1'b0;
			cmd_code_r <= 8'h00;
			cmd_arg_r <= 16'h0000;
			addr_ptr_r <= 16'h0000;
		end else begin
			cmd_valid_r <= state_r == ST_DISPATCH; // R4
			if (state_r == ST_DISPATCH) begin
				cmd_code_r <= frame_mem[pkt_r];
				cmd_arg_r <= {frame_mem[pkt_r + 8'h01],
					frame_mem[pkt_r + 8'h02]};
				if (frame_mem[pkt_r] == CMD_SET_PTR) begin
					addr_ptr_r <= {frame_mem[pkt_r + 8'h01],
						frame_mem[pkt_r + 8'h02]}; // R7
				end
			end
		end
	end

	// Reply content is latched on the edge that takes the checksum byte or fires the auto frame
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			reply_len_r <= 8'h00;
			for (int i = 0; i < 7; i++) begin
				reply_r[i] <= 8'h00;
			end
		end else if (state_r == ST_IDLE && auto_fire
				&& !(lnk.rx_valid && lnk.rx_byte == FRAME_HEADER)) begin
			reply_r[0] <= ACK_BYTE; // R12
			reply_r[1] <= AUTO_FRAME_LEN;
			reply_r[2] <= auto_data[31:24];
			reply_r[3] <= auto_data[23:16];
			reply_r[4] <= auto_data[15:8];
			reply_r[5] <= auto_data[7:0];
			reply_r[6] <= auto_sum; // R10 R12
			reply_len_r <= AUTO_FRAME_LEN; // R9
		end else if (state_r == ST_RECV && lnk.rx_valid && rx_last) begin
			reply_r[0] <= (sum_r == lnk.rx_byte) ? ACK_BYTE
				: CHECKSUM_FAIL_REPLY; // R11
			reply_len_r <= 8'h01;
		end
	end

	// Byte is latched together with its strobe, so the port never sees
	// the index that has already moved on to the next byte
	always_ff @(posedge clk_sys) begin
		if (!rst_b || state_r != ST_REPLY) begin
			tx_go_r <= 1'b0;
			tx_idx_r <= 8'h00;
			tx_byte_r <= 8'h00;
		end else begin
			tx_go_r <= 1'b0;
			if (!lnk.tx_busy && !tx_go_r && tx_idx_r != reply_len_r) begin
				tx_go_r <= 1'b1;
				tx_byte_r <= reply_r[tx_idx_r[2:0]]; // R12
				tx_idx_r <= tx_idx_r + 8'h01;
			end
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	a_only_dispatch: assert property ( // R4
		cmd_valid_r |-> $past(state_r) == ST_DISPATCH)
		else $error("command issued outside dispatch");
	a_ptr_load: assert property ( // R7
		cmd_valid_r && cmd_code_r == CMD_SET_PTR
		|-> addr_ptr_r == cmd_arg_r)
		else $error("pointer not loaded from packet");
	a_csum_fail: assert property ( // R11
		state_r == ST_RECV && lnk.rx_valid && rx_last
		&& sum_r != lnk.rx_byte && tmo_r != 24'(TIMEOUT_CYC - 1)
		|=> state_r == ST_REPLY && reply_r[0] == CHECKSUM_FAIL_REPLY
		&& !cmd_valid_r)
		else $error("checksum failure not answered");
	a_stray_byte: assert property ( // R1
		state_r == ST_IDLE && lnk.rx_valid && lnk.rx_byte != FRAME_HEADER
		&& !auto_fire |=> state_r == ST_IDLE)
		else $error("stray byte opened a frame");
	a_short_count: assert property ( // R14
		state_r == ST_RECV && lnk.rx_valid && idx_r == 8'h01
		&& lnk.rx_byte < MIN_FRAME_LEN && tmo_r != 24'(TIMEOUT_CYC - 1)
		|=> state_r == ST_IDLE)
		else $error("short byte count accepted");
	a_timeout: assert property ( // R15
		state_r == ST_RECV && tmo_r == 24'(TIMEOUT_CYC - 1)
		|=> state_r == ST_IDLE)
		else $error("partial frame not dropped");
	a_ack_after: assert property ( // R3
		state_r == ST_DISPATCH && pkt_next == {1'b0, last_idx}
		|=> state_r == ST_REPLY && reply_r[0] == ACK_BYTE ##1 !cmd_valid_r)
		else $error("frame end not acknowledged");
	a_auto_frame: assert property ( // R9
		state_r == ST_IDLE && auto_fire && !lnk.rx_valid
		|=> state_r == ST_REPLY && reply_len_r == AUTO_FRAME_LEN
		&& reply_r[0] == ACK_BYTE && reply_r[6] == $past(auto_sum))
		else $error("auto frame not started");
endmodule

// ---- rtl/serial_if.sv ----
interface serial_if;
	logic [7:0] rx_byte;
	logic rx_valid;
	logic [7:0] tx_byte;
	logic tx_go;
	logic tx_busy;
	logic tx_line;
	modport port (output rx_byte, rx_valid, tx_busy, tx_line,
		input tx_byte, tx_go);
	modport core (input rx_byte, rx_valid, tx_busy, tx_line,
		output tx_byte, tx_go);
endinterface

// ---- rtl/serial_port.sv ----
module serial_port #(
	parameter int BIT_CYC = frame_rx_pkg::BIT_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic rx_pin,
	serial_if.port lnk
);
	import frame_rx_pkg::*;

	logic rx_meta_r, rx_sync_r, rx_busy_r, tx_busy_r, tx_line_r, rx_valid_r;
	logic [15:0] rx_cnt_r, tx_cnt_r;
	logic [3:0] rx_bit_r, tx_bit_r;
	logic [7:0] rx_sh_r;
	logic [9:0] tx_sh_r;

	assign lnk.rx_byte = rx_sh_r;
	assign lnk.rx_valid = rx_valid_r;
	assign lnk.tx_busy = tx_busy_r;
	assign lnk.tx_line = tx_line_r;

	// Pin crosses from the host's timing; only the second stage is read
	always_ff @(posedge clk_sys) begin
		rx_meta_r <= rx_pin;
		rx_sync_r <= rx_meta_r;
	end

	// Mid-bit sampling, LSB first; a stop bit of 0 drops the byte
	always_ff @(posedge clk_sys) begin
		rx_valid_r <= 1'b0;
		if (!rst_b) begin
			rx_busy_r <= 1'b0;
			rx_cnt_r <= 16'h0000;
			rx_bit_r <= 4'h0;
			rx_sh_r <= 8'h00;
		end else if (!rx_busy_r) begin
			if (!rx_sync_r) begin
				rx_busy_r <= 1'b1;
				rx_cnt_r <= 16'(BIT_CYC / 2);
				rx_bit_r <= 4'h0;
			end
		end else if (rx_cnt_r != 16'h0000) begin
			rx_cnt_r <= rx_cnt_r - 16'h0001;
		end else begin
			rx_cnt_r <= 16'(BIT_CYC - 1);
			rx_bit_r <= rx_bit_r + 4'h1;
			if (rx_bit_r == 4'h0 && rx_sync_r) begin
				rx_busy_r <= 1'b0; // Glitch, not a start bit
			end else if (rx_bit_r == STOP_BIT_IDX) begin
				rx_busy_r <= 1'b0;
				rx_valid_r <= rx_sync_r; // R13
			end else if (rx_bit_r != 4'h0) begin
				rx_sh_r <= {rx_sync_r, rx_sh_r[7:1]};
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			tx_busy_r <= 1'b0;
			tx_line_r <= 1'b1;
			tx_sh_r <= 10'h3ff;
			tx_cnt_r <= 16'h0000;
			tx_bit_r <= 4'h0;
		end else if (!tx_busy_r) begin
			tx_line_r <= 1'b1;
			if (lnk.tx_go) begin
				tx_busy_r <= 1'b1;
				tx_sh_r <= {1'b1, lnk.tx_byte, 1'b0}; // R13
				tx_line_r <= 1'b0;
				tx_cnt_r <= 16'(BIT_CYC - 1);
				tx_bit_r <= 4'h0;
			end
		end else if (tx_cnt_r != 16'h0000) begin
			tx_cnt_r <= tx_cnt_r - 16'h0001;
		end else if (tx_bit_r == STOP_BIT_IDX) begin
			tx_busy_r <= 1'b0;
			tx_line_r <= 1'b1;
		end else begin
			tx_cnt_r <= 16'(BIT_CYC - 1);
			tx_bit_r <= tx_bit_r + 4'h1;
			tx_line_r <= tx_sh_r[1];
			tx_sh_r <= {1'b1, tx_sh_r[9:1]};
		end
	end

	a_tx_start_bit: assert property ( // R13
		@(posedge clk_sys) disable iff (!rst_b)
		!tx_busy_r && lnk.tx_go |=> !tx_line_r && tx_busy_r)
		else $error("start bit not driven");
	a_rx_stop_check: assert property ( // R13
		@(posedge clk_sys) disable iff (!rst_b)
		rx_valid_r |-> $past(rx_bit_r) == STOP_BIT_IDX && $past(rx_sync_r))
		else $error("byte accepted without stop bit");
endmodule

// ---- sim/host_frame_command_receiver_test.sv ----
module host_frame_command_receiver_test;
	timeunit 1ns;
	timeprecision 1ps;
	import frame_rx_pkg::*;

	localparam int BC = 16;
	localparam int TO = 2000;
	localparam int AC = 5000;

	logic clk_sys, rst_b, uart_rx, uart_tx, auto_tx_en, cmd_valid;
	logic [31:0] auto_data;
	logic [7:0] cmd_code;
	logic [15:0] cmd_arg, addr_ptr;
	int error_cnt, cmp_count;
	logic [7:0] cq[$];
	logic [15:0] aq[$];
	logic [7:0] rb;
	logic rok;

	host_frame_command_receiver #(.BIT_CYC(BC), .TIMEOUT_CYC(TO),
		.AUTO_CYC(AC)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
		.uart_rx(uart_rx), .uart_tx(uart_tx), .auto_tx_en(auto_tx_en),
		.auto_data(auto_data), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_arg(cmd_arg), .addr_ptr(addr_ptr));

	host_uart #(.BIT_CYC(BC)) host_u (.clk_sys(clk_sys),
		.tx_line(uart_rx), .rx_line(uart_tx));

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// Log every dispatched command with the values seen in its cycle
	always @(negedge clk_sys) begin
		if (cmd_valid === 1'b1) begin
			cq.push_back(cmd_code);
			aq.push_back(cmd_arg);
		end
	end

	task automatic check(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("Error %0t: %s", $time, msg);
		end
	endtask

	task automatic tally_and_finish;
		if (error_cnt == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic send_frame(input logic [7:0] f[$], input logic [7:0] bad);
		logic [7:0] cs;
		cs = bad;
		foreach (f[i]) begin
			cs = cs + f[i];
			host_u.send(f[i]);
		end
		check(cq.size() == 0, "command ran before checksum");
		host_u.send(cs);
	endtask

	task automatic expect_reply(input logic [7:0] exp);
		host_u.recv(TO, rb, rok);
		check(rok && rb === exp, "wrong reply byte");
	endtask

	task automatic t_set_ptr;
		cq.delete();
		aq.delete();
		send_frame({8'ha5, 8'h07, 8'h41, 8'h00, 8'h54, 8'h52}, 8'h00);
		expect_reply(ACK_BYTE);
		check(cq.size() == 2 && cq[0] === 8'h41 && cq[1] === 8'h52,
			"command order");
		check(aq[0] === 16'h0054 && addr_ptr === 16'h0054, "pointer");
	endtask

	task automatic t_each_cmd;
		logic [7:0] codes[16] = '{8'h52, 8'h44, 8'h57, 8'h45, 8'h4e, 8'h4d,
			8'h4c, 8'h4b, 8'h41, 8'h53, 8'h42, 8'h50, 8'h4f, 8'h5a, 8'h7a,
			8'h76};
		int lens[16] = '{1, 1, 3, 5, 2, 3, 2, 2, 3, 2, 2, 18, 2, 2, 2, 2};
		logic [7:0] f[$];
		for (int k = 0; k < 16; k++) begin
			cq.delete();
			aq.delete();
			f = {8'ha5, 8'(lens[k] + 3), codes[k]};
			for (int j = 1; j < lens[k]; j++)
				f.push_back(8'(j));
			send_frame(f, 8'h00);
			expect_reply(ACK_BYTE);
			check(cq.size() == 1 && cq[0] === codes[k], "length");
			if (lens[k] >= 3)
				check(aq[0] === 16'h0102, "command argument");
		end
	endtask

	task automatic t_bad_cs;
		cq.delete();
		send_frame({8'ha5, 8'h05, 8'h4c, 8'h4d}, 8'h01);
		expect_reply(CHECKSUM_FAIL_REPLY);
		check(cq.size() == 0, "command ran despite bad checksum");
	endtask

	task automatic expect_silence(input string msg);
		host_u.recv(20 * BC, rb, rok);
		check(!rok && cq.size() == 0, msg);
	endtask

	task automatic t_bad_frame;
		cq.delete();
		send_frame({8'h5a, 8'h05, 8'h4c, 8'h4d}, 8'h00);
		expect_silence("reply to unframed bytes");
		send_frame({8'ha5, 8'h05, 8'h41, 8'h00}, 8'h00);
		expect_silence("count mismatch accepted");
		send_frame({8'ha5, 8'h03}, 8'h00);
		expect_silence("short byte count accepted");
		send_frame({8'ha5, 8'h04, 8'h60}, 8'h00);
		expect_silence("unknown command accepted");
	endtask

	task automatic t_timeout;
		cq.delete();
		host_u.send(8'ha5);
		host_u.send(8'h07);
		host_u.send(8'h41);
		host_u.wait_cyc(TO + 200);
		send_frame({8'ha5, 8'h05, 8'h4b, 8'h4d}, 8'h00);
		expect_reply(ACK_BYTE);
		check(cq.size() == 1 && cq[0] === 8'h4b, "stale frame kept");
	endtask

	task automatic t_auto;
		logic [7:0] exp[7] = '{ACK_BYTE, AUTO_FRAME_LEN, 8'h11, 8'h22,
			8'h33, 8'h44, 8'h00};
		cq.delete();
		for (int i = 0; i < 6; i++)
			exp[6] = exp[6] + exp[i];
		@(negedge clk_sys);
		auto_data = 32'h11223344;
		auto_tx_en = 1'b1;
		host_u.recv(AC + 2000, rb, rok);
		check(rok && rb === exp[0], "auto frame header");
		for (int i = 1; i < 7; i++) begin
			host_u.recv(4 * BC, rb, rok);
			check(rok && rb === exp[i], "auto frame byte");
		end
		@(negedge clk_sys);
		auto_tx_en = 1'b0;
		check(cq.size() == 0, "auto frame dispatched a command");
	endtask

	initial begin
		repeat (100000) @(posedge clk_sys);
		error_cnt++;
		tally_and_finish();
	end

	initial begin
		error_cnt = 0;
		cmp_count = 0;
		rst_b = 1'b0;
		auto_tx_en = 1'b0;
		auto_data = 32'h00000000;
		repeat (4) @(negedge clk_sys);
		rst_b = 1'b1;
		check(uart_tx === 1'b1 && addr_ptr === 16'h0000
			&& cmd_valid === 1'b0 && cmd_code === 8'h00
			&& cmd_arg === 16'h0000, "reset state");
		t_set_ptr();
		t_each_cmd();
		t_bad_cs();
		t_bad_frame();
		t_timeout();
		t_auto();
		tally_and_finish();
	end
endmodule

// ---- sim/host_uart.sv ----
module host_uart #(
	parameter int BIT_CYC = 16
) (
	input wire logic clk_sys,
	output logic tx_line,
	input wire logic rx_line
);
	timeunit 1ns;
	timeprecision 1ps;

	initial tx_line = 1'b1;

	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// Ends at mid stop bit so a prompt reply is never missed
	task automatic send(input logic [7:0] b);
		wait_cyc(BIT_CYC / 2);
		tx_line = 1'b0;
		wait_cyc(BIT_CYC);
		for (int i = 0; i < 8; i++) begin
			tx_line = b[i];
			wait_cyc(BIT_CYC);
		end
		tx_line = 1'b1;
		wait_cyc(BIT_CYC / 2);
	endtask

	task automatic recv(input int lim, output logic [7:0] b,
		output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		b = 8'h00;
		while (rx_line !== 1'b0 && n < lim) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= lim)
			return;
		wait_cyc(BIT_CYC / 2);
		for (int i = 0; i < 8; i++) begin
			wait_cyc(BIT_CYC);
			b[i] = rx_line;
		end
		wait_cyc(BIT_CYC);
		ok = (rx_line === 1'b1);
	endtask
endmodule
